// [design/chtr_regs.sv]
/*
 * Integration test registers of a memory card host: test control, input capture and output drive,
 * plus the test multiplexers on intra-chip and card-bus signals and the data-port FIFO gating.
 * Assumes an APB master on the register side and synchronous inputs on sys_clk.
 */
`include "chtr_defs.svh"
`default_nettype none
module chtr_regs
	import chtr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:2] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Data-port access strobes from the host's APB decode
	input wire logic fifo_data_port_read,
	input wire logic fifo_data_port_write,
	input wire logic direction_transmit,
	input wire logic [31:0] fifo_data_port_wdata,
	input wire logic [31:0] fifo_read_data,
	output logic [31:0] fifo_data_port_rdata,
	output logic fifo_pop,
	output logic fifo_push,
	output logic [31:0] fifo_push_data,
	// Protection bypass for the host's access guard
	output logic register_protection_bypass,
	// Intra-chip signals
	input wire logic dma_clear_input,
	output logic dma_clear_internal,
	input wire chtr_intra_t intra_functional,
	output chtr_intra_t intra_out,
	// Card-bus signals
	input wire logic command_line_input,
	input wire logic [3:0] card_data_inputs,
	input wire chtr_card_t card_functional,
	output chtr_card_t card_out,
	input wire logic command_output_enable_n_func,
	input wire logic data0_output_enable_n_func,
	input wire logic upper_data_output_enable_n_func,
	output logic command_output_enable_n,
	output logic data0_output_enable_n,
	output logic upper_data_output_enable_n
);
	chtr_state_t st_r; // Registered state
	chtr_state_t st_nxt; // Next state
	logic wr_en; // APB write in access phase
	logic rd_en; // APB read in setup phase, data ready at access
	logic ten; // Integration test enable
	logic [31:0] rd_word; // Read mux
	logic [2:0] oe_func_n; // Functional enables: command in bit 2, data 0 in bit 1, upper data in bit 0
	logic [2:0] oe_pad_n; // Enables after the test multiplexers, low drives the pad

	// Byte offset match on word address
	function automatic logic hit(input logic [11:2] a, input logic [11:0] ofs);
		hit = (a == ofs[11:2]);
	endfunction : hit

	assign ten = st_r.integration_test_enable;
	// A write lands at the access edge; read data is fetched at the setup edge
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	// No wait states, no errors: unmapped reads give zero
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = st_r.prdata;
	assign register_protection_bypass = st_r.register_protection_bypass;

	// Test multiplexers on the outputs and the DMA clear input
	always_comb begin
		intra_out = ten ? st_r.intra_drive : intra_functional;
		card_out = ten ? st_r.card_drive : card_functional;
		dma_clear_internal = ten ? st_r.dma_clear_stored : dma_clear_input;
	end

	// One test multiplexer per card line enable; forced low so test values reach the pads
	assign oe_func_n = {command_output_enable_n_func, data0_output_enable_n_func, upper_data_output_enable_n_func};
	for (genvar g = 0; g < 3; g++) begin : g_oe_mux
		assign oe_pad_n[g] = ten ? 1'b0 : oe_func_n[g];
	end
	assign command_output_enable_n = oe_pad_n[2];
	assign data0_output_enable_n = oe_pad_n[1];
	assign upper_data_output_enable_n = oe_pad_n[0];

	// Data-port gating per FIFO test mode; reserved code behaves as normal
	always_comb begin
		fifo_data_port_rdata = fifo_read_data;
		fifo_push_data = fifo_data_port_wdata;
		fifo_pop = 1'b0;
		fifo_push = 1'b0;
		unique case (st_r.fifo_test_select)
			CHTR_FT_READ: begin
				fifo_pop = fifo_data_port_read;
				fifo_push = fifo_data_port_write && direction_transmit;
			end
			CHTR_FT_LOOP: begin
				fifo_pop = fifo_data_port_read;
				// A read also pushes the fixed pattern; a write still pushes its data
				fifo_push = fifo_data_port_read || fifo_data_port_write;
				fifo_push_data = fifo_data_port_read ? `CHTR_FIFO_PATTERN : fifo_data_port_wdata;
			end
			default: begin
				fifo_pop = fifo_data_port_read && !direction_transmit;
				fifo_push = fifo_data_port_write && direction_transmit;
			end
		endcase
		// A refused read returns zero rather than whatever the FIFO port shows
		if (fifo_data_port_read && !fifo_pop) begin
			fifo_data_port_rdata = 32'h0000_0000; // Read has no effect
		end
	end

	// Register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit(paddr, `CHTR_TEST_CONTROL_OFS)) begin
			rd_word[`CHTR_REGISTER_PROTECTION_BYPASS_BIT] = st_r.register_protection_bypass;
			rd_word[`CHTR_FTEST_HI:`CHTR_FTEST_LO] = st_r.fifo_test_select;
			rd_word[`CHTR_INTEGRATION_TEST_ENABLE_BIT] = st_r.integration_test_enable;
		end else if (hit(paddr, `CHTR_INPUT_CAPTURE_OFS)) begin
			rd_word[`CHTR_CMDIN_BIT] = command_line_input;
			rd_word[`CHTR_DATIN_HI:`CHTR_DATIN_LO] = card_data_inputs;
			rd_word[`CHTR_DCLR_BIT] = dma_clear_internal;
		end else if (hit(paddr, `CHTR_OUTPUT_DRIVE_OFS)) begin
			rd_word[`CHTR_POWER_BIT:`CHTR_DATOUT_LO] = st_r.card_drive;
			// Intra bits show the live mux outputs only in test mode, otherwise the stored value
			rd_word[`CHTR_INTRA_HI:0] = ten ? intra_out : st_r.intra_drive;
		end
	end

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		// Latched at the setup edge, so the word stands through the whole access phase
		if (rd_en) begin
			st_nxt.prdata = rd_word;
		end
		if (wr_en && hit(paddr, `CHTR_TEST_CONTROL_OFS)) begin
			st_nxt.register_protection_bypass = pwdata[`CHTR_REGISTER_PROTECTION_BYPASS_BIT];
			st_nxt.fifo_test_select = chtr_ftest_t'(pwdata[`CHTR_FTEST_HI:`CHTR_FTEST_LO]);
			st_nxt.integration_test_enable = pwdata[`CHTR_INTEGRATION_TEST_ENABLE_BIT];
		end
		// Input bits 5:1 have no storage, so writes to them simply vanish
		if (wr_en && hit(paddr, `CHTR_INPUT_CAPTURE_OFS)) begin
			st_nxt.dma_clear_stored = pwdata[`CHTR_DCLR_BIT];
		end
		if (wr_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS)) begin
			st_nxt.card_drive = pwdata[`CHTR_POWER_BIT:`CHTR_DATOUT_LO];
			st_nxt.intra_drive = pwdata[`CHTR_INTRA_HI:0];
		end
	end

	// State register
	// Reset clears test mode and all other state at once, so the pads fall back to functional control
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Assertions
	// Test multiplexers: the functional path when off, the written value when on
	a_dclr_mux: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ten |-> dma_clear_internal == dma_clear_input)
		else $error("dma clear mux wrong");
	a_dclr_test: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && hit(paddr, `CHTR_INPUT_CAPTURE_OFS) && ten
		|=> dma_clear_internal == $past(pwdata[`CHTR_DCLR_BIT]))
		else $error("stored dma clear not driven");
	a_intra_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS) && ten |=> intra_out == $past(pwdata[`CHTR_INTRA_HI:0]))
		else $error("intra output not driven");
	a_card_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS) && ten
		|=> card_out == $past(pwdata[`CHTR_POWER_BIT:`CHTR_DATOUT_LO]))
		else $error("card output not driven");
	// Card lines must not move while a test value is held
	a_card_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ten && !(wr_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS)) && !(wr_en && hit(paddr, `CHTR_TEST_CONTROL_OFS))
		|=> $stable(card_out))
		else $error("card output moved without a write");
	a_intra_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ten |-> intra_out == intra_functional)
		else $error("intra output not functional");
	a_card_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ten |-> card_out == card_functional)
		else $error("card output not functional");
	a_oe_forced: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ten |-> !command_output_enable_n && !data0_output_enable_n && !upper_data_output_enable_n)
		else $error("output enables not forced");
	a_oe_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ten |-> command_output_enable_n == command_output_enable_n_func
		&& data0_output_enable_n == data0_output_enable_n_func
		&& upper_data_output_enable_n == upper_data_output_enable_n_func)
		else $error("output enables not functional");
	// Register writes and read-back
	a_tcr_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && hit(paddr, `CHTR_TEST_CONTROL_OFS)
		|=> register_protection_bypass == $past(pwdata[`CHTR_REGISTER_PROTECTION_BYPASS_BIT]))
		else $error("protection bypass not stored");
	a_bypass_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(wr_en && hit(paddr, `CHTR_TEST_CONTROL_OFS)) |=> $stable(register_protection_bypass))
		else $error("protection bypass moved without a write");
	a_tcr_fields: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && hit(paddr, `CHTR_TEST_CONTROL_OFS)
		|=> ten == $past(pwdata[`CHTR_INTEGRATION_TEST_ENABLE_BIT])
		&& st_r.fifo_test_select == $past(pwdata[`CHTR_FTEST_HI:`CHTR_FTEST_LO]))
		else $error("test control fields not stored");
	a_tcr_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && hit(paddr, `CHTR_TEST_CONTROL_OFS)
		|=> prdata == {28'h0, $past(register_protection_bypass), 2'($past(st_r.fifo_test_select)), $past(ten)})
		else $error("test control read wrong");
	a_itip_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && hit(paddr, `CHTR_INPUT_CAPTURE_OFS)
		|=> prdata == {26'h0, $past(command_line_input), $past(card_data_inputs), $past(dma_clear_internal)})
		else $error("input capture read wrong");
	a_card_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS)
		|=> prdata[`CHTR_POWER_BIT:`CHTR_DATOUT_LO] == $past(st_r.card_drive))
		else $error("card drive read wrong");
	a_intra_read_on: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS) && ten |=> prdata[`CHTR_INTRA_HI:0] == $past(intra_out))
		else $error("intra read not from mux");
	a_intra_read_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && hit(paddr, `CHTR_OUTPUT_DRIVE_OFS) && !ten |=> prdata[`CHTR_INTRA_HI:0] == $past(st_r.intra_drive))
		else $error("intra read not from storage");
	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_en && !hit(paddr, `CHTR_TEST_CONTROL_OFS) && !hit(paddr, `CHTR_INPUT_CAPTURE_OFS)
		&& !hit(paddr, `CHTR_OUTPUT_DRIVE_OFS) |=> prdata == 32'h0000_0000)
		else $error("unmapped read nonzero");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		prdata[31:12] == 20'h0)
		else $error("reserved bits nonzero");
	a_prdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!rd_en |=> $stable(prdata))
		else $error("read data moved outside a read");
	// Data-port gating
	a_pop_normal: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_NORMAL && direction_transmit |-> !fifo_pop)
		else $error("pop in transmit");
	a_push_normal: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_NORMAL && !direction_transmit |-> !fifo_push)
		else $error("push in receive");
	a_rx_pop: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_NORMAL && fifo_data_port_read && !direction_transmit |-> fifo_pop)
		else $error("receive read did not pop");
	a_tx_push: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_NORMAL && fifo_data_port_write && direction_transmit |-> fifo_push)
		else $error("transmit write did not push");
	// Reserved code behaves as normal mode
	a_rsvd_normal: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_RSVD && direction_transmit |-> !fifo_pop)
		else $error("reserved code popped in transmit");
	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!fifo_data_port_read && !fifo_data_port_write |-> !fifo_pop && !fifo_push)
		else $error("fifo strobe without access");
	a_skip_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fifo_data_port_read && !fifo_pop |-> fifo_data_port_rdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_pop_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fifo_pop |-> fifo_data_port_rdata == fifo_read_data)
		else $error("popped data not returned");
	a_pop_test: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_READ && fifo_data_port_read |-> fifo_pop)
		else $error("test read did not pop");
	a_read_mode_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_READ && !direction_transmit |-> !fifo_push)
		else $error("read test mode pushed in receive");
	a_loop_pattern: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_LOOP && fifo_data_port_read
		|-> fifo_pop && fifo_push && fifo_push_data == `CHTR_FIFO_PATTERN)
		else $error("loop read pattern missing");
	a_loop_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.fifo_test_select == CHTR_FT_LOOP && fifo_data_port_write |-> fifo_push)
		else $error("loop write dropped");
	a_push_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fifo_push && !fifo_data_port_read |-> fifo_push_data == fifo_data_port_wdata)
		else $error("pushed data not the write data");
endmodule : chtr_regs
`default_nettype wire

// [include/chtr_defs.svh]
/*
 * Offsets, field positions, reset values and codes for the card host test registers.
 * Assumes a word-addressed APB-style register port with 32-bit data.
 */
`ifndef CHTR_DEFS_SVH
`define CHTR_DEFS_SVH

// Register byte offsets
`define CHTR_TEST_CONTROL_OFS 12'h100
`define CHTR_INPUT_CAPTURE_OFS 12'h104
`define CHTR_OUTPUT_DRIVE_OFS 12'h108
// Implemented widths
`define CHTR_TCR_W 4
`define CHTR_ITIP_W 6
`define CHTR_ITOP_W 12
// Reset values
`define CHTR_TCR_RST 4'h0
`define CHTR_ITIP_RST 1'h0
`define CHTR_ITOP_RST 12'h000
// Test control fields
`define CHTR_INTEGRATION_TEST_ENABLE_BIT 0
`define CHTR_FTEST_LO 1
`define CHTR_FTEST_HI 2
`define CHTR_REGISTER_PROTECTION_BYPASS_BIT 3
// Input capture fields
`define CHTR_DCLR_BIT 0
`define CHTR_DATIN_LO 1
`define CHTR_DATIN_HI 4
`define CHTR_CMDIN_BIT 5
// Output drive fields
`define CHTR_INTRA_HI 5
`define CHTR_DATOUT_LO 6
`define CHTR_DATOUT_HI 9
`define CHTR_CMDOUT_BIT 10
`define CHTR_POWER_BIT 11
// Pattern written into the FIFO by a read in loop-back test mode
`define CHTR_FIFO_PATTERN 32'ha5a5_5a5a

`endif

// [include/chtr_pkg.sv]
/*
 * Types shared by the card host test register block.
 * Assumes chtr_defs.svh is on the include path.
 */
`default_nettype none
package chtr_pkg;
	// FIFO test mode codes
	typedef enum logic [1:0] {
		CHTR_FT_NORMAL = 2'b00,
		CHTR_FT_READ = 2'b01,
		CHTR_FT_RSVD = 2'b10,
		CHTR_FT_LOOP = 2'b11
	} chtr_ftest_t;

	// Intra-chip output group
	typedef struct packed {
		logic dma_last_burst_request;
		logic dma_last_single_request;
		logic dma_burst_request;
		logic dma_single_request;
		logic interrupt_line_one;
		logic interrupt_line_zero;
	} chtr_intra_t;

	// Card-bus output group
	typedef struct packed {
		logic card_power_output;
		logic command_line_output;
		logic [3:0] card_data_outputs;
	} chtr_card_t;

	// Whole state of the block
	typedef struct packed {
		logic register_protection_bypass;
		chtr_ftest_t fifo_test_select;
		logic integration_test_enable;
		logic dma_clear_stored;
		chtr_card_t card_drive;
		chtr_intra_t intra_drive;
		logic [31:0] prdata;
	} chtr_state_t;
endpackage : chtr_pkg
`default_nettype wire

// [sim/chtr_apb_master.sv]
/* APB master standing in for the test interface controller.
 * Assumes pready is sampled on rising edges and requests start on falling edges. */
`default_nettype none
module chtr_apb_master (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:2] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// One setup plus access cycle; every register access goes through here
	task xfer(input logic wr, input logic [11:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
		@(negedge sys_clk);
		psel = 1'b1;
		pwrite = wr;
		paddr = ofs[11:2];
		pwdata = wd;
		@(negedge sys_clk);
		penable = 1'b1;
		// Hold everything until ready is seen high
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		@(negedge sys_clk);
		psel = 1'b0;
		penable = 1'b0;
		// Released lines flip so a stale value never looks valid
		paddr = ~paddr;
		pwdata = ~pwdata;
	endtask : xfer
endmodule : chtr_apb_master
`default_nettype wire

// [sim/chtr_regs_tb_top.sv]
/* Self-checking bench for the card host test registers.
 * Assumes the APB master model and that all side inputs change on falling edges. */
`include "chtr_defs.svh"
`default_nettype none
module chtr_regs_tb_top;
	import chtr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, frd, fwr, dir, pop, push, byp;
	logic dcl_in, dcl_int, cmd_in, en_f, oe_c, oe_d0, oe_du;
	logic [11:2] paddr;
	logic [3:0] dat_in;
	logic [31:0] pwdata, prdata, fwd, frdata, prt_rd, push_d, rd;
	chtr_intra_t intra_f, intra_o;
	chtr_card_t card_f, card_o;
	int fails, checks_done, cycles;
	chtr_apb_master apb (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready));
	chtr_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fifo_data_port_read(frd), .fifo_data_port_write(fwr), .direction_transmit(dir),
		.fifo_data_port_wdata(fwd), .fifo_read_data(frdata), .fifo_data_port_rdata(prt_rd), .fifo_pop(pop),
		.fifo_push(push), .fifo_push_data(push_d), .register_protection_bypass(byp),
		.dma_clear_input(dcl_in), .dma_clear_internal(dcl_int), .intra_functional(intra_f), .intra_out(intra_o),
		.command_line_input(cmd_in), .card_data_inputs(dat_in), .card_functional(card_f), .card_out(card_o),
		.command_output_enable_n_func(en_f), .data0_output_enable_n_func(en_f),
		.upper_data_output_enable_n_func(en_f), .command_output_enable_n(oe_c),
		.data0_output_enable_n(oe_d0), .upper_data_output_enable_n(oe_du));
	// Clock at 25 MHz
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Verdict and stop
	task end_sim;
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	// Cut a hang short; the whole run needs a little over a hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			end_sim;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [11:0] o, input logic [31:0] d);
		apb.xfer(1'b1, o, d, rd);
	endtask : wr
	task rdc(input logic [11:0] o, input logic [31:0] e);
		apb.xfer(1'b0, o, 32'h0, rd);
		chk(rd, e);
	endtask : rdc
	// Reset values, unmapped place, control bits and bypass line
	task t_ctrl;
		rdc(`CHTR_TEST_CONTROL_OFS, 32'h0);
		rdc(`CHTR_OUTPUT_DRIVE_OFS, 32'h0);
		rdc(12'h10c, 32'h0);
		chk({pready, pslverr}, 2'b10);
		wr(`CHTR_TEST_CONTROL_OFS, 32'hffff_fff8);
		rdc(`CHTR_TEST_CONTROL_OFS, 32'h8);
		chk(byp, 1'b1);
		chk({oe_c, oe_d0, oe_du}, 3'h7);
	endtask : t_ctrl
	// DMA clear path: stored bit in test mode, pin otherwise; live pins in 5:1
	task t_input;
		wr(`CHTR_TEST_CONTROL_OFS, 32'h1);
		chk({oe_c, oe_d0, oe_du}, 3'h0);
		wr(`CHTR_INPUT_CAPTURE_OFS, 32'hffff_ffff);
		rdc(`CHTR_INPUT_CAPTURE_OFS, 32'h2d);
		chk(dcl_int, 1'b1);
		wr(`CHTR_INPUT_CAPTURE_OFS, 32'h0);
		rdc(`CHTR_INPUT_CAPTURE_OFS, 32'h2c);
		wr(`CHTR_TEST_CONTROL_OFS, 32'h0);
		@(negedge sys_clk) dcl_in = 1'b1;
		#1 chk(dcl_int, 1'b1);
		rdc(`CHTR_INPUT_CAPTURE_OFS, 32'h2d);
	endtask : t_input
	// Output muxes and the two read paths
	task t_output;
		wr(`CHTR_TEST_CONTROL_OFS, 32'h1);
		wr(`CHTR_OUTPUT_DRIVE_OFS, 32'hffff_fa5c);
		chk(card_o, 6'h29);
		chk(intra_o, 6'h1c);
		rdc(`CHTR_OUTPUT_DRIVE_OFS, 32'ha5c);
		wr(`CHTR_TEST_CONTROL_OFS, 32'h0);
		chk(card_o, card_f);
		chk(intra_o, intra_f);
		rdc(`CHTR_OUTPUT_DRIVE_OFS, 32'ha5c);
	endtask : t_output
	// Every FIFO test code in both directions, a read then a write
	task t_fifo;
		logic ep;
		for (int m = 0; m < 4; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr(`CHTR_TEST_CONTROL_OFS, 32'(m << 1));
				ep = (m == 1 || m == 3) ? 1'b1 : ~d[0];
				@(negedge sys_clk);
				dir = d[0];
				frd = 1'b1;
				#1 chk(pop, ep);
				chk(prt_rd, ep ? frdata : 32'h0);
				chk(push, m == 3);
				if (m == 3) chk(push_d, `CHTR_FIFO_PATTERN);
				@(negedge sys_clk);
				frd = 1'b0;
				fwr = 1'b1;
				#1 chk({pop, push}, {1'b0, m == 3 || d == 1});
				if (m == 3 || d == 1) chk(push_d, fwd);
				@(negedge sys_clk) fwr = 1'b0;
			end
		end
	endtask : t_fifo
	// Main sequence
	initial begin
		{sys_rst, frd, fwr, dir, dcl_in, en_f} = 6'h21;
		{cmd_in, dat_in} = 5'h16;
		{fwd, frdata} = {32'h1234_5678, 32'hcafe_0042};
		intra_f = 6'h23;
		card_f = 6'h16;
		{fails, checks_done, cycles} = '0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk) sys_rst = 1'b0;
		t_ctrl;
		t_input;
		t_output;
		t_fifo;
		end_sim;
	end
endmodule : chtr_regs_tb_top
`default_nettype wire
